// *** inc/eeprom_cmd_pkg.sv ***
package eeprom_cmd_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int MEM_BYTES = 128;
  localparam int ADDR_W    = 7;
  localparam int DATA_W    = 16;
  localparam int SH_W      = 16;
  localparam int CNT_W     = 5;

  // ----------------------------------------------------------------
  // frame lengths after the start bit (opcode + address, data)
  // ----------------------------------------------------------------
  localparam logic [4:0] HDR_BITS_WORD  = 5'h08;
  localparam logic [4:0] HDR_BITS_BYTE  = 5'h09;
  localparam logic [4:0] DATA_BITS_WORD = 5'h10;
  localparam logic [4:0] DATA_BITS_BYTE = 5'h08;

  // ----------------------------------------------------------------
  // opcodes and special-group selectors
  // ----------------------------------------------------------------
  localparam logic [1:0] OPC_READ      = 2'h2;
  localparam logic [1:0] OPC_WRITE     = 2'h1;
  localparam logic [1:0] OPC_ERASE     = 2'h3;
  localparam logic [1:0] OPC_SPECIAL   = 2'h0;
  localparam logic [1:0] SEL_ERASE_ALL = 2'h2;
  localparam logic [1:0] SEL_DISABLE   = 2'h0;
  localparam logic [1:0] SEL_ENABLE    = 2'h3;
  localparam logic [1:0] SEL_WRITE_ALL = 2'h1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [15:0] DATA_RST    = 16'h0000;
  localparam logic        ENABLE_RST  = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_MS  = 6;
  localparam int PROG_CYCLES   = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_CNT_W    = 21;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SY_CS    = 0;
  localparam int SY_TOG   = 1;
  localparam int SY_START = 2;
  localparam int SY_RDACT = 3;
  localparam int SY_RDBIT = 4;
  localparam int SY_ORG   = 5;
  localparam int SY_W     = 6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_WRITE, OP_ERASE, OP_ERASE_ALL_CMD,
    OP_WRITE_ALL_CMD, OP_PROGRAM_ENABLE_CMD, OP_PROGRAM_DISABLE_CMD
  } op_t;

  typedef struct packed {
    op_t                op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } cmd_t;

  localparam cmd_t CMD_RST = '{op: OP_NONE, addr: 7'h00, data: DATA_RST};

endpackage : eeprom_cmd_pkg

// *** rtl/eeprom_cmd_logic.sv ***
`timescale 1ns/100ps

module eeprom_cmd_logic
  import eeprom_cmd_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
  parameter bit          HV_VARIANT    = 1'b0
) (
  // system
  input  wire logic clk_in,
  input  wire logic rst_in,
  // serial link
  input  wire logic sclk_in,
  input  wire logic chip_select_in,
  input  wire logic serial_in,
  input  wire logic word_width_select_in,
  output logic      serial_out,
  output logic      serial_oe_out,
  // status
  output logic      ready_busy_flag_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {L_IDLE, L_CMD, L_DATA, L_READ, L_DONE} lst_t;
  typedef enum logic [1:0] {P_IDLE, P_ARMED, P_BUSY} pst_t;

  localparam logic [PROG_CNT_W-1:0] PROG_LAST =
    PROG_CNT_W'(PROG_CYCLES_P - 1);

  logic [7:0]            mem [MEM_BYTES];
  logic                  link_rst_r;
  logic                  link_rst;
  lst_t                  lst_r,      lst_nxt;
  logic [CNT_W-1:0]      cnt_r,      cnt_nxt;
  logic [SH_W-1:0]       sh_r,       sh_nxt;
  logic [ADDR_W-1:0]     rd_addr_r,  rd_addr_nxt;
  logic                  rd_bit_r,   rd_bit_nxt;
  logic                  rd_act_r,   rd_act_nxt;
  logic                  start_r,    start_nxt;
  logic                  tog_r,      tog_nxt;
  cmd_t                  cmd_r,      cmd_nxt;
  logic                  post;
  logic [8:0]            hdr_full;
  logic [15:0]           data_full;
  op_t                   dec_op;
  logic [ADDR_W-1:0]     dec_addr;
  logic [CNT_W-1:0]      hdr_last;
  logic [CNT_W-1:0]      data_last;
  logic [3:0]            rd_msb;
  logic [3:0]            rd_idx;
  logic [15:0]           rd_word;
  logic [SY_W-1:0]       sync1_r;
  logic [SY_W-1:0]       sync2_r;
  logic                  cs_s;
  logic                  org_s;
  logic                  seen_r;
  logic                  start_d_r;
  logic                  ev;
  logic                  prog_op;
  pst_t                  pst_r,      pst_nxt;
  logic [PROG_CNT_W-1:0] pcnt_r,     pcnt_nxt;
  cmd_t                  pcmd_r,     pcmd_nxt;
  logic                  en_r,       en_nxt;
  logic                  stat_r,     stat_nxt;
  logic                  clr_pend_r, clr_pend_nxt;
  logic                  wr_go;
  logic                  so_nxt;
  logic                  oe_nxt;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // opcode/selector split depends on organisation
  function automatic op_t decode_op(input logic word_width_select, input logic [8:0] h);
    logic [1:0] opc;
    logic [1:0] sel;
    opc = word_width_select ? h[7:6] : h[8:7];
    sel = word_width_select ? h[5:4] : h[6:5];
    case (opc)
      OPC_READ:  decode_op = OP_READ;
      OPC_WRITE: decode_op = OP_WRITE;
      OPC_ERASE: decode_op = OP_ERASE;
      default: begin
        case (sel)
          SEL_ERASE_ALL: decode_op = OP_ERASE_ALL_CMD;
          SEL_ENABLE:    decode_op = OP_PROGRAM_ENABLE_CMD;
          SEL_WRITE_ALL: decode_op = OP_WRITE_ALL_CMD;
          default:       decode_op = OP_PROGRAM_DISABLE_CMD;
        endcase
      end
    endcase
  endfunction : decode_op

  // whether byte i is touched by a programming command
  function automatic logic byte_hit(input cmd_t c, input logic word_width_select,
                                    input logic [6:0] i);
    if (c.op == OP_ERASE_ALL_CMD || c.op == OP_WRITE_ALL_CMD)
      byte_hit = 1'b1;
    else if (word_width_select)
      byte_hit = (i[6:1] == c.addr[5:0]);
    else
      byte_hit = (i == c.addr);
  endfunction : byte_hit

  // new contents of byte i
  function automatic logic [7:0] byte_val(input cmd_t c, input logic word_width_select,
                                          input logic [6:0] i);
    if (c.op == OP_ERASE || c.op == OP_ERASE_ALL_CMD)
      byte_val = ERASED_BYTE;
    else if (word_width_select && i[0])
      byte_val = c.data[15:8];
    else
      byte_val = c.data[7:0];
  endfunction : byte_val

  // ----------------------------------------------------------------
  // link domain: serial clock, frame state reset while deselected
  // ----------------------------------------------------------------
  assign link_rst  = ~chip_select_in | link_rst_r;
  assign hdr_full  = {sh_r[7:0], serial_in};
  assign data_full = {sh_r[14:0], serial_in};
  assign dec_op    = decode_op(word_width_select_in, hdr_full);
  assign dec_addr  = word_width_select_in ? {1'b0, hdr_full[5:0]}
                                          : hdr_full[6:0];
  assign hdr_last  = (word_width_select_in ? HDR_BITS_WORD
                                           : HDR_BITS_BYTE) - 5'h01;
  assign data_last = (word_width_select_in ? DATA_BITS_WORD
                                           : DATA_BITS_BYTE) - 5'h01;
  assign rd_msb    = word_width_select_in ? 4'hf : 4'h7;
  assign rd_idx    = rd_msb - cnt_r[3:0];
  // the array only changes when a programming cycle ends; nothing stops a read from starting while busy
  assign rd_word   = word_width_select_in ?
                     {mem[{rd_addr_r[5:0], 1'b1}], mem[{rd_addr_r[5:0], 1'b0}]}
                   : {8'h00, mem[rd_addr_r]};

  // frame sequencer
  always_comb begin
    lst_nxt     = lst_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = {sh_r[14:0], serial_in};
    rd_addr_nxt = rd_addr_r;
    rd_bit_nxt  = rd_bit_r;
    start_nxt   = start_r;
    cmd_nxt     = cmd_r;
    post        = 1'b0;
    case (lst_r)
      L_IDLE: begin
        if (serial_in) begin
          lst_nxt   = L_CMD;
          cnt_nxt   = '0;
          start_nxt = 1'b1;
        end
      end
      L_CMD: begin
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == hdr_last) begin
          cnt_nxt      = '0;
          cmd_nxt.op   = dec_op;
          cmd_nxt.addr = dec_addr;
          case (dec_op)
            OP_READ: begin
              lst_nxt     = L_READ;
              rd_addr_nxt = dec_addr;
              rd_bit_nxt  = 1'b0;
            end
            OP_WRITE, OP_WRITE_ALL_CMD: lst_nxt = L_DATA;
            default: begin
              lst_nxt = L_DONE;
              post    = 1'b1;
            end
          endcase
        end
      end
      L_DATA: begin
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == data_last) begin
          cmd_nxt.data = word_width_select_in ? data_full
                                              : {8'h00, data_full[7:0]};
          lst_nxt = L_DONE;
          post    = 1'b1;
        end
      end
      L_READ: begin
        rd_bit_nxt = rd_word[rd_idx];
        cnt_nxt    = cnt_r + 5'h01;
        if (cnt_r[3:0] == rd_msb) begin
          cnt_nxt     = '0;
          rd_addr_nxt = word_width_select_in ?
                        {1'b0, rd_addr_r[5:0] + 6'h01} : rd_addr_r + 7'h01;
        end
      end
      L_DONE: lst_nxt = L_DONE;
      default: lst_nxt = L_IDLE;
    endcase
  end

  assign rd_act_nxt = (lst_nxt == L_READ);
  assign tog_nxt    = tog_r ^ post;

  // frame state, cleared whenever select is low
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      lst_r     <= L_IDLE;
      cnt_r     <= '0;
      sh_r      <= '0;
      rd_addr_r <= '0;
      rd_bit_r  <= 1'b0;
      rd_act_r  <= 1'b0;
      start_r   <= 1'b0;
    end else begin
      lst_r     <= lst_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      rd_addr_r <= rd_addr_nxt;
      rd_bit_r  <= rd_bit_nxt;
      rd_act_r  <= rd_act_nxt;
      start_r   <= start_nxt;
    end
  end

  // command hand-off survives deselect; toggle marks a new command
  always_ff @(posedge sclk_in or posedge link_rst_r) begin
    if (link_rst_r) begin
      tog_r <= 1'b0;
      cmd_r <= CMD_RST;
    end else begin
      tog_r <= tog_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // system domain: crossing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    link_rst_r <= rst_in;
    sync1_r    <= {word_width_select_in, rd_bit_r, rd_act_r, start_r,
                   tog_r, chip_select_in};
    sync2_r    <= sync1_r;
  end

  assign cs_s    = sync2_r[SY_CS];
  assign org_s   = sync2_r[SY_ORG];
  assign ev      = sync2_r[SY_TOG] ^ seen_r;
  assign prog_op = (cmd_r.op == OP_ERASE) || (cmd_r.op == OP_WRITE) ||
                   (cmd_r.op == OP_ERASE_ALL_CMD) ||
                   (cmd_r.op == OP_WRITE_ALL_CMD);

  // ----------------------------------------------------------------
  // system domain: enable latch and programming cycle
  // ----------------------------------------------------------------
  always_comb begin
    pst_nxt      = pst_r;
    pcnt_nxt     = pcnt_r;
    pcmd_nxt     = pcmd_r;
    en_nxt       = en_r;
    stat_nxt     = stat_r;
    clr_pend_nxt = clr_pend_r;
    wr_go        = 1'b0;
    // enable latch, only power/reset or disable drop it
    if (ev && cmd_r.op == OP_PROGRAM_ENABLE_CMD)
      en_nxt = 1'b1;
    if (ev && cmd_r.op == OP_PROGRAM_DISABLE_CMD)
      en_nxt = 1'b0;
    // start bit after completion, then select low, drops status
    if (pst_r == P_IDLE && sync2_r[SY_START] && !start_d_r)
      clr_pend_nxt = 1'b1;
    if (clr_pend_r && !cs_s) begin
      clr_pend_nxt = 1'b0;
      stat_nxt     = 1'b0;
    end
    case (pst_r)
      P_IDLE: begin
        if (ev && prog_op && en_r) begin
          pcmd_nxt = cmd_r;
          pcnt_nxt = '0;
          if (HV_VARIANT) begin
            pst_nxt  = P_BUSY;
            stat_nxt = 1'b1;
          end else begin
            pst_nxt = P_ARMED;
          end
        end
      end
      P_ARMED: begin
        if (!cs_s) begin
          pst_nxt  = P_BUSY;
          stat_nxt = 1'b1;
        end
      end
      P_BUSY: begin
        pcnt_nxt = pcnt_r + 1'b1;
        if (pcnt_r == PROG_LAST) begin
          pst_nxt = P_IDLE;
          wr_go   = 1'b1;
        end
      end
      default: pst_nxt = P_IDLE;
    endcase
  end

  // pin drive: read data first, then ready/busy status
  always_comb begin
    so_nxt = 1'b0;
    oe_nxt = 1'b0;
    if (cs_s && sync2_r[SY_RDACT]) begin
      so_nxt = sync2_r[SY_RDBIT];
      oe_nxt = 1'b1;
    end else if (cs_s && stat_r) begin
      so_nxt = (pst_r != P_BUSY);
      oe_nxt = 1'b1;
    end
  end

  // control registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pst_r      <= P_IDLE;
      pcnt_r     <= '0;
      pcmd_r     <= CMD_RST;
      en_r       <= ENABLE_RST;
      stat_r     <= 1'b0;
      clr_pend_r <= 1'b0;
      seen_r     <= 1'b0;
      start_d_r  <= 1'b0;
    end else begin
      pst_r      <= pst_nxt;
      pcnt_r     <= pcnt_nxt;
      pcmd_r     <= pcmd_nxt;
      en_r       <= en_nxt;
      stat_r     <= stat_nxt;
      clr_pend_r <= clr_pend_nxt;
      seen_r     <= sync2_r[SY_TOG];
      start_d_r  <= sync2_r[SY_START];
    end
  end

  // output flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serial_out          <= 1'b0;
      serial_oe_out       <= 1'b0;
      ready_busy_flag_out <= 1'b1;
    end else begin
      serial_out          <= so_nxt;
      serial_oe_out       <= oe_nxt;
      ready_busy_flag_out <= (pst_nxt != P_BUSY);
    end
  end

  // array update at end of cycle; erase-then-program in one step
  always_ff @(posedge clk_in) begin
    if (wr_go) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        if (byte_hit(pcmd_r, org_s, 7'(i)))
          mem[i] <= byte_val(pcmd_r, org_s, 7'(i));
      end
    end
  end

endmodule : eeprom_cmd_logic

// *** dv/eeprom_cmd_logic_sva.sv ***
`timescale 1ns/100ps
module eeprom_cmd_logic_sva
  import eeprom_cmd_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // serial link
  input wire logic sclk_in,
  input wire logic chip_select_in,
  input wire logic serial_in,
  input wire logic word_width_select_in,
  input wire logic serial_out,
  input wire logic serial_oe_out,
  // status
  input wire logic ready_busy_flag_out
);
  localparam int BUSY_MAX = 1000;
  logic [PROG_CNT_W-1:0] busy_cnt_r;

  // length of the running busy stretch
  always_ff @(posedge clk_in) begin
    if (rst_in || ready_busy_flag_out)
      busy_cnt_r <= '0;
    else
      busy_cnt_r <= busy_cnt_r + 1'b1;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_oe_off;
    $fell(chip_select_in) |-> ##[1:5] !serial_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output still driven after deselect");
  property p_oe_idle;
    !chip_select_in [*6] |-> !serial_oe_out;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  property p_oe_cs;
    $rose(serial_oe_out) |-> chip_select_in;
  endproperty
  a_oe_cs: assert property (p_oe_cs)
    else $error("output enabled without select");
  property p_status_busy;
    !ready_busy_flag_out [*4] ##0 serial_oe_out |-> !serial_out;
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("status not low while busy");
  property p_busy_start;
    $fell(ready_busy_flag_out) |-> !$past(chip_select_in, 2);
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy began with select high");
  property p_busy_min;
    $fell(ready_busy_flag_out) |-> !ready_busy_flag_out [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy stretch too short");
  property p_busy_bound;
    $fell(ready_busy_flag_out) |-> ##[1:BUSY_MAX] ready_busy_flag_out;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy never ended");
  property p_busy_len;
    $rose(ready_busy_flag_out) |-> busy_cnt_r + 1 >= PROG_CYCLES_P
      && busy_cnt_r <= PROG_CYCLES_P + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length differs from parameter");
endmodule : eeprom_cmd_logic_sva

bind eeprom_cmd_logic eeprom_cmd_logic_sva #(
  .PROG_CYCLES_P(PROG_CYCLES_P)
) u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk_in),
  .chip_select_in(chip_select_in), .serial_in(serial_in),
  .word_width_select_in(word_width_select_in),
  .serial_out(serial_out), .serial_oe_out(serial_oe_out),
  .ready_busy_flag_out(ready_busy_flag_out)
);

// *** dv/eeprom_master_model.sv ***
`timescale 1ns/100ps
module eeprom_master_model (
  // link towards the device
  output logic     sclk_out,
  output logic     chip_select_out,
  output logic     serial_data_out,
  input wire logic device_data_in,
  input wire logic device_oe_in
);
  // released line reads as z so it never passes for data
  wire dq_w = device_oe_in ? device_data_in : 1'bz;

  // idle levels, link clock still
  initial begin
    sclk_out = 1'b0;
    chip_select_out = 1'b0;
    serial_data_out = 1'b0;
  end

  // one selected frame of n bits, msb first, line sampled before edges
  task automatic frame(input int n, input logic [63:0] w,
                       output logic [63:0] rd);
    rd = '0;
    chip_select_out = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_out = w[i];
      #62.5;
      rd = {rd[62:0], dq_w};
      sclk_out = 1'b1;
      #62.5;
      sclk_out = 1'b0;
    end
    #62.5;
    rd = {rd[62:0], dq_w};
    chip_select_out = 1'b0;
    #300;
  endtask : frame

  // select briefly and read the status line
  task automatic poll(output logic s);
    chip_select_out = 1'b1;
    #200;
    s = dq_w;
    chip_select_out = 1'b0;
    #300;
  endtask : poll
endmodule : eeprom_master_model

// *** dv/eeprom_cmd_logic_tb.sv ***
`timescale 1ns/100ps
module eeprom_cmd_logic_tb;
  import eeprom_cmd_pkg::*;
  localparam int unsigned PROG_N = 200;
  logic        clk_in;
  logic        rst_in;
  logic        org_r;
  wire         sclk_w, cs_w, si_w, so_w, oe_w, rdy_w;
  int          n_errors;
  int          tests_run;
  logic [63:0] rd;
  logic        s;
  logic [6:0]  a, last;
  logic [15:0] d;

  eeprom_cmd_logic #(.PROG_CYCLES_P(PROG_N)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk_w),
    .chip_select_in(cs_w), .serial_in(si_w),
    .word_width_select_in(org_r), .serial_out(so_w),
    .serial_oe_out(oe_w), .ready_busy_flag_out(rdy_w)
  );
  eeprom_master_model m (
    .sclk_out(sclk_w), .chip_select_out(cs_w), .serial_data_out(si_w),
    .device_data_in(so_w), .device_oe_in(oe_w)
  );

  // clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // helpers for word size
  function automatic int nd();
    return org_r ? 16 : 8;
  endfunction : nd
  function automatic logic [15:0] mask(input logic [15:0] v);
    return org_r ? v : {8'h00, v[7:0]};
  endfunction : mask
  function automatic logic [6:0] sel(input logic [1:0] s2);
    return org_r ? {1'b0, s2, 4'h0} : {s2, 5'h00};
  endfunction : sel

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // build and send one instruction frame
  task automatic send(input logic [1:0] op, input logic [6:0] ad,
                      input logic [15:0] dt, input int nb);
    logic [63:0] w;
    w = {62'h1, op};
    w = org_r ? (w << 6) | 64'(ad[5:0]) : (w << 7) | 64'(ad);
    w = (w << nb) | (64'(mask(dt)) & ((64'h1 << nb) - 64'h1));
    m.frame((org_r ? 9 : 10) + nb, w, rd);
  endtask : send

  // read nw words and compare
  task automatic rdchk(input logic [6:0] ad, input logic [15:0] e0,
                       input logic [15:0] e1, input int nw);
    int          k;
    logic [63:0] km;
    k = nd();
    // one word only: bits above it are the released line or the dummy bit
    km = (64'h1 << k) - 64'h1;
    send(OPC_READ, ad, 16'h0, nw * k);
    check((rd >> (nw * k)) & 64'h1, 64'h0);
    check((rd >> ((nw - 1) * k)) & km, 64'(mask(e0)));
    if (nw == 2) check(rd & km, 64'(mask(e1)));
  endtask : rdchk

  // programming frame: 0 refused, 1 polled, 2 select kept low
  task automatic prog(input logic [1:0] op, input logic [6:0] ad,
                      input logic [15:0] dt, input int nb, input int go);
    send(op, ad, dt, nb);
    check(rdy_w, go == 0);
    if (go == 1) begin
      m.poll(s);
      check(s, 1'b0);
    end
    if (go != 0) begin
      for (int i = 0; i < 1000 && rdy_w !== 1'b1; i++) @(posedge clk_in);
      check(rdy_w, 1'b1);
      m.poll(s);
      check(s, 1'b1);
      m.frame(1, 64'h1, rd);
      m.poll(s);
      check(s, 1'bz);
    end
  endtask : prog

  // verdict
  task automatic results();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // watchdog, about three times the expected run, under 100k clock cycles
  initial begin
    #360000;
    n_errors++;
    results();
  end

  // main sequence, both word sizes
  initial begin
    rst_in = 1'b1;
    org_r = 1'b0;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(32'h8698c391));
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_in);
      org_r <= p[0];
      rst_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      last = org_r ? 7'h3f : 7'h7f;
      a = 7'($urandom_range(1, org_r ? 62 : 126));
      d = 16'($urandom);
      prog(OPC_WRITE, a, d, nd(), 0);
      send(OPC_SPECIAL, sel(SEL_ENABLE), 16'h0, 0);
      prog(OPC_SPECIAL, sel(SEL_ERASE_ALL), 16'h0, 0, 1);
      rdchk(a, 16'hffff, 16'hffff, 2);
      prog(OPC_WRITE, a, d, nd(), 1);
      prog(OPC_WRITE, last, ~d, nd(), 2);
      rdchk(last, ~d, 16'hffff, 2);
      rdchk(a, d, 16'h0, 1);
      prog(OPC_ERASE, a, 16'h0, 0, 1);
      rdchk(a, 16'hffff, 16'h0, 1);
      m.frame(5, 64'h0, rd);
      check(rdy_w, 1'b1);
      prog(OPC_WRITE, a, d, nd() - 3, 0);
      rdchk(a, 16'hffff, 16'h0, 1);
      send(OPC_SPECIAL, sel(SEL_DISABLE), 16'h0, 0);
      prog(OPC_SPECIAL, sel(SEL_WRITE_ALL), d, nd(), 0);
      send(OPC_SPECIAL, sel(SEL_ENABLE), 16'h0, 0);
      prog(OPC_SPECIAL, sel(SEL_WRITE_ALL), d, nd(), 1);
      rdchk(last, d, d, 2);
      send(OPC_SPECIAL, sel(SEL_DISABLE), 16'h0, 0);
    end
    results();
  end
endmodule : eeprom_cmd_logic_tb
